// ### core/tw_defines.svh
// Register offsets, field positions, reset values and status codes.
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// Register offsets on the plain register port.
`define TW_OFS_CTRL      2'h0
`define TW_OFS_STATUS    2'h1
`define TW_OFS_DATA      2'h2
`define TW_OFS_RATE      2'h3

// Field positions inside the control register.
`define TW_CTRL_FLAG     7
`define TW_CTRL_ACKEN    6
`define TW_CTRL_START    5
`define TW_CTRL_STOP     4
`define TW_CTRL_WCOL     3
`define TW_CTRL_EN       2
`define TW_CTRL_IE       0

// Field positions inside the status register.
`define TW_STAT_CODE_HI  7
`define TW_STAT_CODE_LO  3
`define TW_STAT_PS_HI    1
`define TW_STAT_PS_LO    0

// Reset values.
`define TW_RST_DATA      8'hff
`define TW_RST_RATE      8'h04
`define TW_RST_PS        2'h0

// Status codes placed in the code field.
`define TW_SC_START      5'h01
`define TW_SC_RSTART     5'h02
`define TW_SC_AW_ACK     5'h03
`define TW_SC_AW_NACK    5'h04
`define TW_SC_TX_ACK     5'h05
`define TW_SC_TX_NACK    5'h06
`define TW_SC_AR_ACK     5'h07
`define TW_SC_AR_NACK    5'h08
`define TW_SC_RX_ACK     5'h0a
`define TW_SC_RX_NACK    5'h0b
`define TW_SC_IDLE       5'h1f

`endif

// ### core/tw_pkg.sv
// Types shared by the two-wire handshake controller.
`default_nettype none
package tw_pkg;

	// Bus sequencer states.
	typedef enum logic [3:0] {
		TW_IDLE       = 4'b0000,
		TW_WAIT_FREE  = 4'b0001,
		TW_START_HOLD = 4'b0010,
		TW_HOLD       = 4'b0011,
		TW_BIT_LOW    = 4'b0100,
		TW_BIT_HIGH   = 4'b0101,
		TW_ACK_LOW    = 4'b0110,
		TW_ACK_HIGH   = 4'b0111,
		TW_RS_LOW     = 4'b1000,
		TW_RS_HIGH    = 4'b1001,
		TW_STOP_LOW   = 4'b1010,
		TW_STOP_HIGH  = 4'b1011
	} tw_state_t;

	// Whole state of the controller.
	typedef struct packed {
		tw_state_t   st;
		logic        flag;
		logic        ack_en;
		logic        sta;
		logic        stop_req_bit;
		logic        wcol;
		logic        en;
		logic        block_irq_en;
		logic [1:0]  rate_prescale_sel;
		logic [7:0]  rate;
		logic [7:0]  data;
		logic [4:0]  state_code_field;
		logic [15:0] cnt;
		logic [2:0]  bitn;
		logic        addr_ph;
		logic        rd_mode;
		logic        own;
		logic        busy;
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		logic        scl_f;
		logic        sda_f;
		logic        scl_drv;
		logic        sda_drv;
		logic [7:0]  rdata;
	} tw_regs_t;

endpackage
`default_nettype wire

// ### core/tw_ctrl.sv
// Two-wire bus master with a flag-based software handshake.
`default_nettype none
`include "tw_defines.svh"

// Overview of operation
// - Every bus event except STOP sets the completion flag.
// - Interrupt needs flag, block and global enables.
// - Status code valid whenever flag is set.
// - Writing one to flag clears it.
// - No bus operation while flag is set.
// - Clearing flag starts the requested operation.
// - START done sets flag with START code.
// - Byte sent sets flag, code shows acknowledge.
// - One data register sends address and data.
// - Data byte sent sets flag and status.
// - STOP leaves flag clear, no event.
// - Clock line held low while flag set, until a disable frees it.
// - Code in bits 7:3, prescaler low bits.
// - START waits for a free bus.
// - STOP request bit clears itself after STOP.
// - Interrupt stays while flag stays high.
module tw_ctrl
	import tw_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       cpu_irq_en_i,
	output logic            irq_o,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_o,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.
	////////////////////////////////////////////////////////////////////////

	// Half of one bus clock period in system clocks.
	// The prescaler multiplies by 1, 4, 16 or 64.
	function automatic logic [15:0] half_period(input logic [7:0] rate,
		input logic [1:0] ps);
		logic [15:0] base;
		base = {8'h00, rate} + 16'h0001;
		case (ps)
			2'h0:    half_period = base;
			2'h1:    half_period = base << 2;
			2'h2:    half_period = base << 4;
			default: half_period = base << 6;
		endcase
	endfunction

	// Status code after an acknowledge slot completes.
	function automatic logic [4:0] ack_code(input logic addr_ph,
		input logic rd, input logic rx, input logic nack,
		input logic ack_sent);
		if (addr_ph) begin
			if (rd) begin
				ack_code = nack ? `TW_SC_AR_NACK : `TW_SC_AR_ACK;
			end else begin
				ack_code = nack ? `TW_SC_AW_NACK : `TW_SC_AW_ACK;
			end
		end else if (rx) begin
			ack_code = ack_sent ? `TW_SC_RX_ACK : `TW_SC_RX_NACK;
		end else begin
			ack_code = nack ? `TW_SC_TX_NACK : `TW_SC_TX_ACK;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State.
	////////////////////////////////////////////////////////////////////////

	tw_regs_t    r_reg;   // Registered state.
	tw_regs_t    r_next;  // Next state.
	logic [15:0] hp;      // Reload value of the bit-phase counter.
	logic        tick;    // Current bit phase has run out.
	logic        rx;      // The byte under way is received, not sent.

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	////////////////////////////////////////////////////////////////////////

	// All behaviour lives here; later assignments win, so hardware
	// setting the flag overrides a software clear in the same cycle.
	always_comb begin
		r_next = r_reg;
		hp     = half_period(r_reg.rate, r_reg.rate_prescale_sel);
		tick   = (r_reg.cnt == 16'h0000);
		rx     = r_reg.rd_mode & ~r_reg.addr_ph;

		// Read data is shown for one cycle only, zero otherwise.
		r_next.rdata = 8'h00;

		// Three-stage synchronisers; a level is accepted only once the
		// second and third stage agree, which also rejects short glitches.
		r_next.scl_s = {r_reg.scl_s[1:0], scl_i};
		r_next.sda_s = {r_reg.sda_s[1:0], sda_i};
		if (r_reg.scl_s[1] == r_reg.scl_s[2]) begin
			r_next.scl_f = r_reg.scl_s[2];
		end
		if (r_reg.sda_s[1] == r_reg.sda_s[2]) begin
			r_next.sda_f = r_reg.sda_s[2];
		end

		// Bus-busy tracking: data falling with clock high is START,
		// data rising with clock high is STOP, whoever made them.
		if (r_reg.scl_f && r_next.scl_f) begin
			if (r_reg.sda_f && !r_next.sda_f) begin
				r_next.busy = 1'b1;
			end else if (!r_reg.sda_f && r_next.sda_f) begin
				r_next.busy = 1'b0;
			end
		end

		// Bit-phase timer free-runs and reloads when it expires.
		r_next.cnt = tick ? hp : r_reg.cnt - 16'h0001;

		//------------------------------------------------------------------
		// Register reads.
		//------------------------------------------------------------------
		if (rd_i) begin
			if (addr_i == `TW_OFS_CTRL) begin
				r_next.rdata[`TW_CTRL_FLAG]  = r_reg.flag;
				r_next.rdata[`TW_CTRL_ACKEN] = r_reg.ack_en;
				r_next.rdata[`TW_CTRL_START] = r_reg.sta;
				r_next.rdata[`TW_CTRL_STOP]  = r_reg.stop_req_bit;
				r_next.rdata[`TW_CTRL_WCOL]  = r_reg.wcol;
				r_next.rdata[`TW_CTRL_EN]    = r_reg.en;
				r_next.rdata[`TW_CTRL_IE]    = r_reg.block_irq_en;
			end else if (addr_i == `TW_OFS_STATUS) begin
				// Code high, reserved bit zero, prescaler low.
				r_next.rdata[`TW_STAT_CODE_HI:`TW_STAT_CODE_LO] =
					r_reg.state_code_field;
				r_next.rdata[`TW_STAT_PS_HI:`TW_STAT_PS_LO] =
					r_reg.rate_prescale_sel;
			end else if (addr_i == `TW_OFS_DATA) begin
				r_next.rdata = r_reg.data;
			end else begin
				r_next.rdata = r_reg.rate;
			end
		end

		//------------------------------------------------------------------
		// Register writes.
		//------------------------------------------------------------------
		if (wr_i) begin
			if (addr_i == `TW_OFS_CTRL) begin
				r_next.ack_en       = wdata_i[`TW_CTRL_ACKEN];
				r_next.sta          = wdata_i[`TW_CTRL_START];
				r_next.stop_req_bit = wdata_i[`TW_CTRL_STOP];
				r_next.en           = wdata_i[`TW_CTRL_EN];
				r_next.block_irq_en = wdata_i[`TW_CTRL_IE];
				// Only a one clears the flag; a zero leaves it alone.
				if (wdata_i[`TW_CTRL_FLAG]) begin
					r_next.flag = 1'b0;
				end
			end else if (addr_i == `TW_OFS_STATUS) begin
				r_next.rate_prescale_sel =
					wdata_i[`TW_STAT_PS_HI:`TW_STAT_PS_LO];
			end else if (addr_i == `TW_OFS_DATA) begin
				// The byte may only change while the engine waits;
				// otherwise the write is dropped and flagged.
				if (r_reg.flag) begin
					r_next.data = wdata_i;
					r_next.wcol = 1'b0;
				end else begin
					r_next.wcol = 1'b1;
				end
			end else begin
				r_next.rate = wdata_i;
			end
		end

		//------------------------------------------------------------------
		// Bus sequencer.
		//------------------------------------------------------------------
		case (r_reg.st)
			TW_IDLE: begin
				// Lines released; a START request leaves idle only once
				// the flag is clear.
				r_next.scl_drv = 1'b0;
				r_next.sda_drv = 1'b0;
				if (r_reg.en && r_reg.sta && !r_reg.flag) begin
					r_next.st = TW_WAIT_FREE;
				end
			end
			TW_WAIT_FREE: begin
				// Another master holds the bus: wait for its STOP.
				if (!r_reg.busy && r_reg.scl_f) begin
					r_next.sda_drv = 1'b1;
					r_next.cnt     = hp;
					r_next.st      = TW_START_HOLD;
				end
			end
			TW_START_HOLD: begin
				// START hold time done: pull clock low and report.
				if (tick) begin
					r_next.scl_drv          = 1'b1;
					r_next.flag             = 1'b1;
					r_next.state_code_field = r_reg.own ?
						`TW_SC_RSTART : `TW_SC_START;
					r_next.own              = 1'b1;
					r_next.addr_ph          = 1'b1;
					r_next.st               = TW_HOLD;
				end
			end
			TW_HOLD: begin
				// Clock is stretched low for as long as the flag stands.
				r_next.scl_drv = 1'b1;
				if (!r_reg.flag) begin
					r_next.cnt = hp;
					if (r_reg.sta) begin
						// Repeated START: free data, then raise clock.
						r_next.sda_drv = 1'b0;
						r_next.st      = TW_RS_LOW;
					end else if (r_reg.stop_req_bit) begin
						r_next.sda_drv = 1'b1;
						r_next.st      = TW_STOP_LOW;
					end else begin
						// Byte taken from the data register as it
						// stands now.
						r_next.bitn    = 3'h7;
						r_next.sda_drv = ~rx & ~r_reg.data[7];
						r_next.st      = TW_BIT_LOW;
					end
				end
			end
			TW_BIT_LOW: begin
				if (tick) begin
					r_next.scl_drv = 1'b0;
					r_next.st      = TW_BIT_HIGH;
				end
			end
			TW_BIT_HIGH: begin
				// A slave stretching the clock holds the phase timer.
				if (!r_reg.scl_f) begin
					r_next.cnt = hp;
				end else if (tick) begin
					// Bus bit shifts in while ours shifts out.
					r_next.data    = {r_reg.data[6:0], r_reg.sda_f};
					r_next.scl_drv = 1'b1;
					if (r_reg.bitn == 3'h0) begin
						r_next.sda_drv = rx & r_reg.ack_en;
						r_next.st      = TW_ACK_LOW;
					end else begin
						r_next.bitn    = r_reg.bitn - 3'h1;
						r_next.sda_drv = ~rx & ~r_reg.data[6];
						r_next.st      = TW_BIT_LOW;
					end
				end
			end
			TW_ACK_LOW: begin
				if (tick) begin
					r_next.scl_drv = 1'b0;
					r_next.st      = TW_ACK_HIGH;
				end
			end
			TW_ACK_HIGH: begin
				if (!r_reg.scl_f) begin
					r_next.cnt = hp;
				end else if (tick) begin
					// Byte done: clock low, report outcome, wait.
					r_next.scl_drv          = 1'b1;
					r_next.sda_drv          = 1'b0;
					r_next.flag             = 1'b1;
					r_next.state_code_field = ack_code(r_reg.addr_ph,
						r_reg.data[0], rx, r_reg.sda_f,
						r_reg.ack_en);
					if (r_reg.addr_ph) begin
						r_next.rd_mode = r_reg.data[0];
					end
					r_next.addr_ph          = 1'b0;
					r_next.st               = TW_HOLD;
				end
			end
			TW_RS_LOW: begin
				if (tick) begin
					r_next.scl_drv = 1'b0;
					r_next.st      = TW_RS_HIGH;
				end
			end
			TW_RS_HIGH: begin
				if (!r_reg.scl_f) begin
					r_next.cnt = hp;
				end else if (tick) begin
					r_next.sda_drv = 1'b1;
					r_next.st      = TW_START_HOLD;
				end
			end
			TW_STOP_LOW: begin
				if (tick) begin
					r_next.scl_drv = 1'b0;
					r_next.st      = TW_STOP_HIGH;
				end
			end
			TW_STOP_HIGH: begin
				if (!r_reg.scl_f) begin
					r_next.cnt = hp;
				end else if (tick) begin
					// STOP out: no flag, request bit self-clears.
					r_next.sda_drv          = 1'b0;
					r_next.stop_req_bit     = 1'b0;
					r_next.own              = 1'b0;
					r_next.rd_mode          = 1'b0;
					r_next.state_code_field = `TW_SC_IDLE;
					r_next.st               = TW_IDLE;
				end
			end
			default: begin
				r_next.st = TW_IDLE;
			end
		endcase

		// Disabling aborts whatever is under way and frees the lines.
		if (!r_reg.en) begin
			r_next.st      = TW_IDLE;
			r_next.scl_drv = 1'b0;
			r_next.sda_drv = 1'b0;
			r_next.own     = 1'b0;
			r_next.rd_mode = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	////////////////////////////////////////////////////////////////////////

	// Synchronous reset; synchronisers reset to the idle-high bus.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			r_reg                   <= '0;
			r_reg.st                <= TW_IDLE;
			r_reg.data              <= `TW_RST_DATA;
			r_reg.rate              <= `TW_RST_RATE;
			r_reg.rate_prescale_sel <= `TW_RST_PS;
			r_reg.state_code_field  <= `TW_SC_IDLE;
			r_reg.scl_s             <= 3'h7;
			r_reg.sda_s             <= 3'h7;
			r_reg.scl_f             <= 1'b1;
			r_reg.sda_f             <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.
	////////////////////////////////////////////////////////////////////////

	// Open-drain lines only ever pull low.
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_o = r_reg.scl_drv;
	assign sda_oe_o = r_reg.sda_drv;
	assign rdata_o  = r_reg.rdata;

	// Level request: follows the flag, not cleared by servicing.
	assign irq_o = r_reg.flag & r_reg.block_irq_en
		& cpu_irq_en_i;

endmodule
`default_nettype wire

// ### verif/tw_ctrl_props.sv
// Port-level assertions for the two-wire handshake controller.
`default_nettype none
`include "tw_defines.svh"
module tw_ctrl_props (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       cpu_irq_en_i,
	input wire logic       irq_o,
	input wire logic       scl_i,
	input wire logic       scl_o,
	input wire logic       scl_oe_o,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// High when software writes the control register this cycle.
	logic ctl_wr;
	assign ctl_wr = wr_i && addr_i == `TW_OFS_CTRL;

	a_irq_needs_global: assert property (irq_o |-> cpu_irq_en_i)
		else $error("interrupt without global enable");
	a_irq_holds_flag: assert property (
		(irq_o && !ctl_wr) ##1 cpu_irq_en_i |-> irq_o)
		else $error("interrupt dropped without a control write");
	a_zero_keeps_flag: assert property (
		(irq_o && ctl_wr && !wdata_i[7] && wdata_i[2] && wdata_i[0])
		##1 cpu_irq_en_i |-> irq_o)
		else $error("flag cleared by writing zero");
	a_clock_held_low: assert property (irq_o |-> scl_oe_o)
		else $error("clock line released while flag set");
	a_no_op_held: assert property (
		irq_o && !ctl_wr |=> $stable(sda_oe_o) && scl_oe_o)
		else $error("bus moved while flag set");
	// The bench keeps the half period at three clocks, so forty is ample.
	a_clear_starts: assert property (
		irq_o && ctl_wr && wdata_i[7] && wdata_i[2] |-> ##[1:40] !scl_oe_o)
		else $error("cleared flag did not start the operation");
	a_start_free_bus: assert property (
		$rose(sda_oe_o) && !scl_oe_o |-> scl_i)
		else $error("start driven while clock line low");
	a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its cycle");
	a_reset_quiet: assert property (disable iff (1'b0)
		reset_i |=> !scl_oe_o && !sda_oe_o && !irq_o)
		else $error("lines driven after reset");
	a_open_drain_low: assert property (!scl_o && !sda_o)
		else $error("open-drain data not low");

	c_irq: cover property (irq_o);
	c_start: cover property ($rose(sda_oe_o) && !scl_oe_o);
	c_read: cover property ($past(rd_i) && rdata_o != 8'h00);
endmodule

bind tw_ctrl tw_ctrl_props tw_ctrl_props_inst (.clk_i(clk_i),
	.reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .cpu_irq_en_i(cpu_irq_en_i),
	.irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
`default_nettype wire

// ### verif/tw_slave_model.sv
// Behavioural target on the two-wire bus: acknowledges, records, sends bytes.
`default_nettype none
module tw_slave_model (
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       nack_i,
	input  wire logic       stretch_i,
	input  wire logic [7:0] tx_i,
	output logic            sda_pull_o,
	output logic            scl_pull_o,
	output logic      [7:0] byte_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;  // Shift register, most significant bit first.
	logic [3:0] cnt; // Clock pulses seen in the current byte.
	logic [7:0] tx;    // Byte being sent to the master in a read.
	logic       rd;    // Target sends the data bytes of this frame.
	logic       first; // The byte under way is the address.
	logic       mack;  // Master acknowledged the last byte sent.
	initial begin
		tx = 8'h00;
		rd = 1'b0;
		first = 1'b1;
		mack = 1'b0;
		sda_pull_o = 1'b0;
		scl_pull_o = 1'b0;
		cnt = 4'h0;
		sh = 8'h00;
		byte_o = 8'h00;
	end
	// A falling data line under a high clock is a start: restart the byte.
	// The short wait keeps a data change beside a falling clock, both in
	// one time step, from being taken for a start.
	always @(negedge sda_i) begin
		#1;
		if (scl_i) begin
			cnt = 4'h0;
			first = 1'b1;
			rd = 1'b0;
		end
	end
	// Data is taken on the rising clock edge, the master's answer too.
	always @(posedge scl_i) begin
		if (cnt < 4'h8)
			sh = {sh[6:0], sda_i};
		if (cnt == 4'h8)
			mack = !sda_i;
		cnt = cnt + 4'h1;
	end
	// Acknowledge is driven in the low phase and dropped after its pulse.
	// In a read the target shifts its byte out in the low phases and lets
	// the line go for the master's answer; a refusal ends its turn.
	always @(negedge scl_i) begin
		if (cnt == 4'h8) begin
			byte_o = sh;
			if (first)
				rd = sh[0] && !nack_i;
			sda_pull_o = (first || !rd) && !nack_i;
		end else if (cnt == 4'h9) begin
			if (!first)
				rd = rd && mack;
			tx = first ? tx_i : {tx[6:0], tx[7]};
			first = 1'b0;
			cnt = 4'h0;
			sda_pull_o = rd && !tx[7];
		end else if (rd && !first) begin
			sda_pull_o = !tx[3'(4'h7 - cnt)];
		end
		// Stretching mid-byte makes the master wait on a slow target.
		if (cnt == 4'h3 && stretch_i) begin
			scl_pull_o = 1'b1;
			scl_pull_o <= #40 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### verif/tw_ctrl_tb.sv
// Self-checking bench for the two-wire handshake controller.
`default_nettype none
`include "tw_defines.svh"
module tw_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic [1:0] addr_i = 2'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       gie = 1'b0;     // Processor global interrupt enable.
	logic       nack = 1'b0;    // Target refuses the next byte.
	logic       stretch = 1'b0; // Target slows the clock.
	logic       ext_sda = 1'b0; // Another master pulling the data line.
	logic [7:0] tx_byte = 8'h00; // First byte the target sends in a read.
	logic [7:0] rdata_o, rx, seen, sa, d;
	logic       irq_o, scl_oe_o, sda_oe_o, s_scl, s_sda, scl_w, sda_w, ie;
	int         failures = 0;
	int         n_compared = 0;
	// Both lines have pull-ups: any party pulling wins.
	assign scl_w = !(scl_oe_o | s_scl);
	assign sda_w = !(sda_oe_o | s_sda | ext_sda);

	tw_ctrl tw_ctrl_inst (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .cpu_irq_en_i(gie), .irq_o, .scl_i(scl_w),
		.scl_o(), .scl_oe_o, .sda_i(sda_w), .sda_o(), .sda_oe_o);
	tw_slave_model tw_slave_model_inst (.scl_i(scl_w), .sda_i(sda_w),
		.nack_i(nack), .stretch_i(stretch), .tx_i(tx_byte),
		.sda_pull_o(s_sda), .scl_pull_o(s_scl), .byte_o(rx));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, got, exp);
		end
	endtask
	// Status register value for a code, prescaler bits at zero.
	function automatic logic [7:0] stat(input logic [4:0] sc);
		return {sc, 3'b000};
	endfunction
	// The target rotates its byte left once for each further read byte.
	function automatic logic [7:0] rot(input logic [7:0] b);
		return {b[6:0], b[7]};
	endfunction
	// A gap cycle follows each strobe so no signal is set twice at once.
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
		v = rdata_o;
	endtask
	task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		check(v, exp);
	endtask
	// Software polls the flag, the block enable being optional.
	task automatic step(input logic [7:0] c, input logic [7:0] st);
		wr(`TW_OFS_CTRL, c);
		seen = 8'h00;
		for (int i = 0; i < 400 && !seen[7]; i++)
			rd(`TW_OFS_CTRL, seen);
		check(8'(seen[7]), 8'h01);
		rdc(`TW_OFS_STATUS, st);
	endtask
	task automatic stop(input logic en);
		wr(`TW_OFS_CTRL, 8'h94 | 8'(en));
		seen = 8'h10;
		for (int i = 0; i < 100 && seen[4]; i++)
			rd(`TW_OFS_CTRL, seen);
		check(seen, 8'h04 | 8'(en));
		rdc(`TW_OFS_STATUS, 8'hf8);
	endtask
	task automatic conclude();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#200us;
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(32'he04c_6eff));
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rdc(`TW_OFS_STATUS, 8'hf8);
		rdc(`TW_OFS_DATA, `TW_RST_DATA);
		rdc(`TW_OFS_RATE, `TW_RST_RATE);
		rdc(`TW_OFS_CTRL, 8'h00);
		wr(`TW_OFS_STATUS, 8'h03);
		rdc(`TW_OFS_STATUS, 8'hfb);
		wr(`TW_OFS_STATUS, 8'h00);
		// Half period of three clocks: twelve clocks a bit once the
		// synchroniser delay is added, the nearest to a 64 ns link clock.
		wr(`TW_OFS_RATE, 8'h02);
		wr(`TW_OFS_DATA, 8'h5a);
		rdc(`TW_OFS_CTRL, 8'h08);
		rdc(`TW_OFS_DATA, 8'hff);
		$display("test registers done");
		for (int t = 0; t < 6; t++) begin
			ie = 1'($urandom);
			gie <= 1'($urandom);
			nack <= 1'($urandom);
			stretch <= t[0];
			sa = {7'($urandom), 1'b0};
			d = 8'($urandom);
			if (t == 5)
				d = 8'h00;
			step(8'ha4 | 8'(ie), 8'h08);
			wr(`TW_OFS_DATA, sa);
			wr(`TW_OFS_CTRL, 8'h24 | 8'(ie));
			rdc(`TW_OFS_CTRL, 8'ha4 | 8'(ie));
			check(8'(irq_o), 8'(ie & gie));
			check(8'(scl_oe_o), 8'h01);
			rdc(`TW_OFS_DATA, sa);
			step(8'h84 | 8'(ie), nack ? 8'h20 : 8'h18);
			check(rx, sa);
			nack <= 1'($urandom);
			wr(`TW_OFS_DATA, d);
			step(8'h84 | 8'(ie), nack ? 8'h30 : 8'h28);
			check(rx, d);
			if (t[0])
				step(8'ha4 | 8'(ie), 8'h10);
			stop(ie);
			$display("test transfer %0d done", t);
		end
		// Target sends two bytes: the first acknowledged, the second not.
		nack <= 1'b0;
		tx_byte <= 8'($urandom);
		sa = {7'($urandom), 1'b1};
		step(8'ha4, stat(`TW_SC_START));
		wr(`TW_OFS_DATA, sa);
		step(8'h84, stat(`TW_SC_AR_ACK));
		check(rx, sa);
		step(8'hc4, stat(`TW_SC_RX_ACK));
		rdc(`TW_OFS_DATA, tx_byte);
		step(8'h84, stat(`TW_SC_RX_NACK));
		rdc(`TW_OFS_DATA, rot(tx_byte));
		stop(1'b0);
		$display("test read done");
		// Another master owns the bus: our start waits for its stop.
		ext_sda <= 1'b1;
		repeat (10) @(posedge clk_i);
		wr(`TW_OFS_CTRL, 8'ha4);
		repeat (60) @(posedge clk_i);
		check(8'(sda_oe_o), 8'h00);
		ext_sda <= 1'b0;
		step(8'ha4, 8'h08);
		stop(1'b0);
		$display("test busy bus done");
		conclude();
	end
endmodule
`default_nettype wire
